// ===== clock_config_pkg.sv
// package: register layout and encodings of the run-mode clock configuration
// assumes: used as clock_config_pkg::name, never imported
package clock_config_pkg;
  localparam logic [7:0] config_offset = 8'h60;
  localparam logic [31:0] config_reset = 32'h0780_3ad1;
  localparam logic [31:0] config_writable = 32'h0fc0_2ff3;
  localparam int auto_gating_bit = 27;
  localparam int divisor_hi = 26;
  localparam int divisor_lo = 23;
  localparam int divider_enable_bit = 22;
  localparam int pll_power_down_bit = 13;
  localparam int bypass_bit = 11;
  localparam int crystal_hi = 10;
  localparam int crystal_lo = 6;
  localparam int source_hi = 5;
  localparam int source_lo = 4;
  localparam int internal_disable_bit = 1;
  localparam int main_disable_bit = 0;
  localparam logic [3:0] min_divisor_default = 4'h2;
  localparam logic [4:0] crystal_pll_max = 5'h16;
  localparam logic [4:0] crystal_pll_min = 5'h04;
  localparam logic [1:0] src_main = 2'h0;
  localparam logic [1:0] src_internal = 2'h1;
  localparam logic [1:0] src_internal_div4 = 2'h2;
  localparam logic [1:0] src_slow = 2'h3;
  localparam logic [1:0] div4_count = 2'h3;
  localparam logic [8:0] pll_target_mhz = 9'h190;
  typedef enum logic [1:0]
  {
    mode_run = 2'b00,
    mode_sleep = 2'b01,
    mode_deep_sleep = 2'b10
  } power_mode_t;
endpackage

// ===== clock_enable_divider.sv
// file: one-cycle enable after every divide_by+1 input steps
// assumes: divide_by is stable or changes only at a period boundary
module clock_enable_divider
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic step_in,
  input wire logic [3:0] divide_by_in,
  output logic enable_out
);
  logic [3:0] count;
  logic [3:0] next_count;
  logic next_enable;

  always_comb
  begin
    next_count = count;
    next_enable = 1'b0;
    if (step_in)
    begin
      next_count = count + 4'h1;
      if (count >= divide_by_in)
      begin
        next_count = 4'h0;
        next_enable = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      count <= 4'h0;
      enable_out <= 1'b0;
    end
    else
    begin
      count <= next_count;
      enable_out <= next_enable;
    end
  end
endmodule

// ===== run_mode_clock_config.sv
// file: run-mode clock configuration register and clock selection logic
// assumes: oscillator and pll ticks arrive as async levels; one clock
// Functional notes
// - auto gating: sleep/deep-sleep gating sets used
// - auto gating off: run gating kept
// - run mode always uses run gating
// - four-bit divisor, code n divides n+1
// - pll output halved before divisor
// - pll clamps divisor to minimum limit
// - divider enable; pll forces divider use
// - power-down bit stops the pll
// - bypass selects oscillator, else divided pll
// - five-bit crystal code, reset six mhz
// - two-bit oscillator source select
// - internal oscillator disable bit
// - main oscillator disable, reset set
// - register resets to 0x0780_3ad1, writable only under mask 0x0fc0_2ff3, reads return all bits
// - crystal change recomputes pll settings
//
// The address map and the address-and-strobe port were left to the implementer.
module run_mode_clock_config
#(
  parameter logic [3:0] minimum_divisor_limit = 4'h2
)
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] address_in,
  input wire logic [31:0] write_data_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [31:0] read_data_out,
  input wire logic [1:0] power_mode_in,
  input wire logic [31:0] run_gating_regs_in,
  input wire logic [31:0] sleep_gating_regs_in,
  input wire logic [31:0] deep_sleep_gating_regs_in,
  input wire logic main_oscillator_tick_in,
  input wire logic precision_internal_oscillator_tick_in,
  input wire logic slow_oscillator_tick_in,
  input wire logic pll_tick_in,
  output logic [31:0] peripheral_clock_enables_out,
  output logic system_clock_enable_out,
  output logic pll_power_down_out,
  output logic main_oscillator_enable_out,
  output logic internal_oscillator_enable_out,
  output logic [8:0] pll_multiplier_out,
  output logic [4:0] pll_divider_out
);
  logic [31:0] config_reg;
  logic [31:0] next_config_reg;
  logic [31:0] next_read_data;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] tick_prev;
  logic [3:0] ticks;
  logic [1:0] div4;
  logic [1:0] next_div4;
  logic pll_half;
  logic next_pll_half;
  logic src_pulse;
  logic divided_pulse;
  logic [3:0] active_div;
  logic [3:0] next_active_div;
  logic [31:0] next_gating;
  logic next_sys_enable;
  logic [8:0] next_mult;
  logic [4:0] next_rdiv;
  logic [4:0] crystal_seen;

  // divisor after minimum clamp when pll used
  function automatic logic [3:0] effective_divisor
  (
    input logic [3:0] code,
    input logic use_pll
  );
    effective_divisor = code;
    if (use_pll && code < minimum_divisor_limit)
    begin
      effective_divisor = minimum_divisor_limit;
    end
  endfunction

  wire logic use_pll = !config_reg[clock_config_pkg::bypass_bit];
  wire logic [3:0] div_code =
    config_reg[clock_config_pkg::divisor_hi:clock_config_pkg::divisor_lo];
  wire logic [4:0] crystal =
    config_reg[clock_config_pkg::crystal_hi:clock_config_pkg::crystal_lo];
  wire logic [1:0] source =
    config_reg[clock_config_pkg::source_hi:clock_config_pkg::source_lo];

  // register file
  always_comb
  begin
    next_config_reg = config_reg;
    next_read_data = 32'h0000_0000;
    if (write_in && address_in == clock_config_pkg::config_offset)
    begin
      next_config_reg =
        (write_data_in & clock_config_pkg::config_writable) |
        (clock_config_pkg::config_reset & ~clock_config_pkg::config_writable);
    end
    if (read_in && address_in == clock_config_pkg::config_offset)
    begin
      next_read_data = config_reg;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      config_reg <= clock_config_pkg::config_reset;
      read_data_out <= 32'h0000_0000;
    end
    else
    begin
      config_reg <= next_config_reg;
      read_data_out <= next_read_data;
    end
  end

  // oscillator tick synchronisers
  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      tick_prev <= 4'h0;
    end
    else
    begin
      sync_a <= {pll_tick_in, slow_oscillator_tick_in,
        precision_internal_oscillator_tick_in, main_oscillator_tick_in};
      sync_b <= sync_a;
      tick_prev <= sync_b;
    end
  end

  assign ticks = sync_b & ~tick_prev;

  // source selection and pll halving
  always_comb
  begin
    next_div4 = div4;
    next_pll_half = pll_half;
    if (ticks[1])
    begin
      next_div4 = (div4 == clock_config_pkg::div4_count) ?
        2'h0 : div4 + 2'h1;
    end
    if (ticks[3])
    begin
      next_pll_half = !pll_half;
    end
    src_pulse = 1'b0;
    if (use_pll)
    begin
      src_pulse = ticks[3] && pll_half;
    end
    else
    begin
      unique case (source)
        clock_config_pkg::src_main: src_pulse = ticks[0];
        clock_config_pkg::src_internal: src_pulse = ticks[1];
        clock_config_pkg::src_internal_div4:
          src_pulse = ticks[1] && div4 == clock_config_pkg::div4_count;
        clock_config_pkg::src_slow: src_pulse = ticks[2];
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      div4 <= 2'h0;
      pll_half <= 1'b0;
    end
    else
    begin
      div4 <= next_div4;
      pll_half <= next_pll_half;
    end
  end

  // divider counts source pulses, n gives n+1
  clock_enable_divider system_divider
  (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .step_in(src_pulse),
    .divide_by_in(active_div),
    .enable_out(divided_pulse)
  );

  always_comb
  begin
    next_active_div = active_div;
    if (divided_pulse)
    begin
      next_active_div = effective_divisor(div_code, use_pll);
    end
    next_sys_enable = src_pulse;
    if (config_reg[clock_config_pkg::divider_enable_bit] || use_pll)
    begin
      next_sys_enable = divided_pulse;
    end
  end

  always_comb
  begin
    next_gating = run_gating_regs_in;
    if (config_reg[clock_config_pkg::auto_gating_bit])
    begin
      if (power_mode_in == clock_config_pkg::mode_sleep)
      begin
        next_gating = sleep_gating_regs_in;
      end
      else if (power_mode_in == clock_config_pkg::mode_deep_sleep)
      begin
        next_gating = deep_sleep_gating_regs_in;
      end
    end
  end

  always_comb
  begin
    next_mult = pll_multiplier_out;
    next_rdiv = pll_divider_out;
    if (crystal != crystal_seen)
    begin
      if (crystal >= clock_config_pkg::crystal_pll_min &&
        crystal <= clock_config_pkg::crystal_pll_max)
      begin
        next_mult = clock_config_pkg::pll_target_mhz;
        next_rdiv = crystal - 5'h1;
      end
      else
      begin
        next_mult = 9'h000;
        next_rdiv = 5'h00;
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      active_div <=
        clock_config_pkg::config_reset[clock_config_pkg::divisor_hi:
        clock_config_pkg::divisor_lo];
      system_clock_enable_out <= 1'b0;
      peripheral_clock_enables_out <= 32'h0000_0000;
      pll_power_down_out <= 1'b1;
      main_oscillator_enable_out <= 1'b0;
      internal_oscillator_enable_out <= 1'b1;
      pll_multiplier_out <= 9'h000;
      pll_divider_out <= 5'h00;
      crystal_seen <= 5'h1f;
    end
    else
    begin
      active_div <= next_active_div;
      system_clock_enable_out <= next_sys_enable;
      peripheral_clock_enables_out <= next_gating;
      pll_power_down_out <= config_reg[clock_config_pkg::pll_power_down_bit];
      main_oscillator_enable_out <=
        !config_reg[clock_config_pkg::main_disable_bit];
      internal_oscillator_enable_out <=
        !config_reg[clock_config_pkg::internal_disable_bit];
      pll_multiplier_out <= next_mult;
      pll_divider_out <= next_rdiv;
      crystal_seen <= crystal;
    end
  end

  a_config_reset: assert property (@(posedge clock_in)
    $fell(reset_in) |-> config_reg == clock_config_pkg::config_reset)
    else $error("config not at reset value");
  a_run_gating: assert property (@(posedge clock_in) disable iff (reset_in)
    $past(power_mode_in) == clock_config_pkg::mode_run && !$past(reset_in)
    |-> peripheral_clock_enables_out == $past(run_gating_regs_in))
    else $error("run gating not used in run mode");
  a_sleep_gating: assert property (@(posedge clock_in) disable iff (reset_in)
    config_reg[clock_config_pkg::auto_gating_bit] &&
    power_mode_in == clock_config_pkg::mode_sleep
    |=> peripheral_clock_enables_out == $past(sleep_gating_regs_in))
    else $error("sleep gating not used");
  a_undivided: assert property (@(posedge clock_in) disable iff (reset_in)
    !config_reg[clock_config_pkg::divider_enable_bit] &&
    config_reg[clock_config_pkg::bypass_bit] && src_pulse
    |=> system_clock_enable_out)
    else $error("undivided clock missing");
  a_min_clamp: assert property (@(posedge clock_in) disable iff (reset_in)
    use_pll && divided_pulse |=> active_div >= minimum_divisor_limit)
    else $error("pll divisor below minimum");
  a_pll_down: assert property (@(posedge clock_in) disable iff (reset_in)
    ##1 pll_power_down_out ==
    $past(config_reg[clock_config_pkg::pll_power_down_bit]))
    else $error("pll power-down mismatch");
  a_main_osc: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(config_reg[clock_config_pkg::main_disable_bit])
    |=> main_oscillator_enable_out)
    else $error("main oscillator not enabled");
  a_crystal_pll: assert property (@(posedge clock_in) disable iff (reset_in)
    $changed(crystal) && crystal == clock_config_pkg::crystal_pll_min
    |=> ##1 pll_divider_out == 5'h03)
    else $error("pll settings not recomputed");
endmodule

// ===== tb_top.sv
// bench for the run-mode clock configuration block
// assumes: one 125 MHz clock, register at offset 0x60, default clamp 2
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] rst_v = clock_config_pkg::config_reset;
  localparam logic [31:0] wr_m = clock_config_pkg::config_writable;
  localparam logic [7:0] tbl [8] = '{8'h4d, 8'h4f, 8'h47, 8'h0b,
    8'hbd, 8'hfd, 8'h44, 8'h56};
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] address_in = 8'h00;
  logic [31:0] write_data_in = 32'h0;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic [31:0] read_data_out;
  logic [1:0] power_mode_in = 2'h0;
  logic [31:0] run_g = 32'h0;
  logic [31:0] sleep_g = 32'h0;
  logic [31:0] deep_g = 32'h0;
  logic [5:0] tick = 6'h0;
  logic [31:0] gate_out;
  logic sys_en;
  logic pd_out;
  logic main_oscillator_en;
  logic iosc_en;
  logic [8:0] mult_out;
  logic [4:0] div_out;
  logic [31:0] seed = 32'd93607;
  logic [31:0] exp_g;
  logic rd_d = 1'b0;
  logic [31:0] exp_q [$];
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int cnt;
  int exp_n;
  run_mode_clock_config #(.minimum_divisor_limit(4'h2)) dut
  (
    .clock_in(clock_in), .reset_in(reset_in), .address_in(address_in),
    .write_data_in(write_data_in), .write_in(write_in),
    .read_in(read_in), .read_data_out(read_data_out),
    .power_mode_in(power_mode_in), .run_gating_regs_in(run_g),
    .sleep_gating_regs_in(sleep_g), .deep_sleep_gating_regs_in(deep_g),
    .main_oscillator_tick_in(tick[3]),
    .precision_internal_oscillator_tick_in(tick[2]),
    .slow_oscillator_tick_in(tick[5]), .pll_tick_in(tick[0]),
    .peripheral_clock_enables_out(gate_out),
    .system_clock_enable_out(sys_en), .pll_power_down_out(pd_out),
    .main_oscillator_enable_out(main_oscillator_en),
    .internal_oscillator_enable_out(iosc_en),
    .pll_multiplier_out(mult_out), .pll_divider_out(div_out)
  );
  initial
  begin
    forever #4 clock_in = ~clock_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // pulses expected in 1024 cycles for one table entry
  function automatic int pulses(input logic [7:0] e);
    int per;
    int dv;
    int n;
    per = (e[7:6] == 2'h0) ? 16 : (e[7:6] == 2'h1) ? 8 :
      (e[7:6] == 2'h2) ? 32 : 64;
    dv = int'(e[5:2]);
    n = 1024 / per;
    if (!e[0])
      return 256 / (((dv < 2) ? 2 : dv) + 1);
    if (e[1])
      return n / (dv + 1);
    return n;
  endfunction
  task automatic stop_test;
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    address_in <= a;
    write_data_in <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    address_in <= a;
    read_in <= 1'b1;
    exp_q.push_back(want);
    @(posedge clock_in);
    read_in <= 1'b0;
  endtask
  task automatic lvl(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // oscillator ticks and run timeout
  always @(posedge clock_in)
  begin
    tick <= tick + 6'h1;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch++;
      stop_test;
    end
  end
  // read data compared in the cycle after the strobe
  always @(posedge clock_in)
  begin
    rd_d <= read_in;
    if (rd_d)
      check(read_data_out, exp_q.pop_front());
  end
  initial
  begin
    repeat (10) @(posedge clock_in);
    reset_in <= 1'b0;
    lvl(3);
    check(pd_out, 1'b1);
    check(main_oscillator_en, 1'b0);
    check(iosc_en, 1'b1);
    check(mult_out, 9'h190);
    check(div_out, 5'h0a);
    @(posedge clock_in);
    rd(8'h60, rst_v);
    wr(8'h64, 32'hffff_ffff);
    rd(8'h64, 32'h0);
    wr(8'h60, 32'hffff_ffff);
    rd(8'h60, 32'h0fc0_3ff3);
    lvl(2);
    check(pd_out, 1'b1);
    check(main_oscillator_en, 1'b0);
    check(iosc_en, 1'b0);
    @(posedge clock_in);
    wr(8'h60, 32'h0);
    rd(8'h60, 32'h0000_1000);
    lvl(2);
    check(pd_out, 1'b0);
    check(main_oscillator_en, 1'b1);
    check(iosc_en, 1'b1);
    @(posedge clock_in);
    wr(8'h60, rst_v & ~32'h0000_2000);
    rd(8'h60, 32'h0780_1ad1);
    repeat (6)
    begin
      seed = xs(seed);
      wr(8'h60, seed | 32'h0000_0800);
      rd(8'h60, ((seed | 32'h0000_0800) & wr_m) | 32'h0000_1000);
    end
    for (int m = 0; m < 3; m++)
      for (int a = 0; a < 2; a++)
      begin
        wr(8'h60, rst_v | (32'(a) << 27));
        seed = xs(seed);
        run_g <= seed;
        sleep_g <= ~seed;
        deep_g <= {seed[15:0], seed[31:16]};
        power_mode_in <= 2'(m);
        lvl(3);
        exp_g = (a == 1 && m == 1) ? sleep_g :
          (a == 1 && m == 2) ? deep_g : run_g;
        check(gate_out, exp_g);
        @(posedge clock_in);
      end
    power_mode_in <= 2'h0;
    foreach (tbl[i])
    begin
      wr(8'h60, {5'h0, tbl[i][5:2], tbl[i][1], 10'h0, tbl[i][0],
        5'h0b, tbl[i][7:6], 4'h0});
      repeat (300) @(posedge clock_in);
      cnt = 0;
      repeat (1024)
      begin
        @(posedge clock_in);
        #1;
        if (sys_en === 1'b1)
          cnt++;
      end
      n_checks++;
      exp_n = pulses(tbl[i]);
      if (cnt > exp_n + 1 || cnt + 1 < exp_n)
      begin
        n_mismatch++;
        $display("unexpected at %0t: %0d pulses", $time, cnt);
      end
      @(posedge clock_in);
    end
    wr(8'h60, rst_v & ~32'h0000_2000);
    rd(8'h60, 32'h0780_1ad1);
    foreach (tbl[i])
    begin
      logic [4:0] x;
      x = (i == 0) ? 5'h06 : (i == 1) ? 5'h11 : (i == 2) ? 5'h15 :
        (i == 3) ? 5'h03 : 5'h04 + 5'(i - 4);
      wr(8'h60, (rst_v & ~32'h7c0) | (32'(x) << 6));
      lvl(4);
      check(mult_out, (x >= 5'h04) ? 9'h190 : 9'h0);
      check(div_out, (x >= 5'h04) ? x - 5'h01 : 5'h0);
      @(posedge clock_in);
    end
    repeat (3) @(posedge clock_in);
    stop_test;
  end
endmodule
